/* File: eeb_defines.svh */
// Constants of the two-wire serial memory slave
`ifndef EEB_DEFINES_SVH
`define EEB_DEFINES_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define EEB_ADDR_W      13
`define EEB_DATA_W      8
`define EEB_HI_BITS     5
`define EEB_PAGE_BITS   5
`define EEB_MEM_DEPTH   8192

// ----------------------------------------------------------------
// Slave address
// ----------------------------------------------------------------
`define EEB_DEV_TYPE    4'ha
`define EEB_DIR_READ    1'b1

// ----------------------------------------------------------------
// Bit counter positions
// ----------------------------------------------------------------
`define EEB_BIT_FIRST   4'h0
`define EEB_BIT_LAST    4'h8
`define EEB_BIT_ACK     4'h9

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define EEB_CLK_MHZ     100
`define EEB_PROG_TIME_US 5000
`define EEB_PROG_W      20

// ----------------------------------------------------------------
// Buffering
// ----------------------------------------------------------------
`define EEB_FIFO_DEPTH  8

`endif

/* File: eeb_fifo.sv */
// Parameterised FIFO holding bytes waiting to be programmed
`timescale 1ns/1ps

module eeb_fifo #(
    parameter int WIDTH = 21,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk_in,
    input  wire logic             sys_rst_in,
    input  wire logic             in_valid_in,
    output logic                  in_ready_out,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  out_valid_out,
    input  wire logic             out_ready_in,
    output logic [WIDTH-1:0]      out_data_out
);

    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    typedef struct packed {
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [PW:0]   count;
    } eeb_fifo_t;

    eeb_fifo_t        r_reg;
    eeb_fifo_t        r_next;
    logic [WIDTH-1:0] mem_reg [DEPTH];
    logic             do_push;
    logic             do_pop;

    assign in_ready_out  = (r_reg.count != (PW+1)'(DEPTH));
    assign out_valid_out = (r_reg.count != '0);
    assign out_data_out  = mem_reg[r_reg.rd_ptr];
    assign do_push       = in_valid_in && in_ready_out;
    assign do_pop        = out_valid_out && out_ready_in;

    // ----------------------------------------------------------------
    // Pointer and count update
    // ----------------------------------------------------------------
    always_comb
    begin
        r_next = r_reg;
        if (do_push)
        begin
            r_next.wr_ptr = (r_reg.wr_ptr == PW'(DEPTH-1)) ? '0 : r_reg.wr_ptr + 1'b1;
        end
        if (do_pop)
        begin
            r_next.rd_ptr = (r_reg.rd_ptr == PW'(DEPTH-1)) ? '0 : r_reg.rd_ptr + 1'b1;
        end
        if (do_push && !do_pop)
        begin
            r_next.count = r_reg.count + 1'b1;
        end
        else if (do_pop && !do_push)
        begin
            r_next.count = r_reg.count - 1'b1;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (do_push)
        begin
            mem_reg[r_reg.wr_ptr] <= in_data_in;
        end
    end

endmodule

/* File: eeb_mem.sv */
// Nonvolatile array model with one write and one read port
`timescale 1ns/1ps

module eeb_mem #(
    parameter int ADDR_W = 13,
    parameter int DATA_W = 8
) (
    input  wire logic              core_clk_in,
    input  wire logic              sys_rst_in,
    input  wire logic              wr_en_in,
    input  wire logic [ADDR_W-1:0] wr_addr_in,
    input  wire logic [DATA_W-1:0] wr_data_in,
    input  wire logic [ADDR_W-1:0] rd_addr_in,
    output logic [DATA_W-1:0]      rd_data_out
);

    logic [DATA_W-1:0] cell_reg [2**ADDR_W];

    always_ff @(posedge core_clk_in)
    begin
        if (wr_en_in)
        begin
            cell_reg[wr_addr_in] <= wr_data_in;
        end
    end

    // Read data follows the address one cycle later
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            rd_data_out <= '0;
        end
        else
        begin
            rd_data_out <= cell_reg[rd_addr_in];
        end
    end

endmodule

/* File: eeb_mm.sv */
// Behavioural two-wire bus master
`timescale 1ns/1ps

module eeb_mm (
    input  wire logic core_clk_in,
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_oe_out
);
    initial
    begin
        scl_out    = 1'b1;
        sda_oe_out = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk_in);
        #1;
    endtask
    // Start or repeated start
    task automatic start();
        sda_oe_out = 1'b0;
        tick(4);
        scl_out = 1'b1;
        tick(4);
        sda_oe_out = 1'b1;
        tick(4);
        scl_out = 1'b0;
        tick(4);
    endtask
    task automatic stop();
        sda_oe_out = 1'b1;
        tick(4);
        scl_out = 1'b1;
        tick(4);
        sda_oe_out = 1'b0;
        tick(4);
    endtask
    // Eight bits MSB first, then the acknowledge bit
    task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q, output logic ack);
        logic [8:0] w;
        logic [8:0] s;
        w = {d, mack};
        for (int i = 8; i >= 0; i--)
        begin
            sda_oe_out = ~w[i];
            tick(4);
            scl_out = 1'b1;
            tick(4);
            s[i] = sda_in;
            tick(4);
            scl_out = 1'b0;
            tick(4);
        end
        q = s[8:1];
        ack = ~s[0];
    endtask
endmodule

/* File: eeb_pkg.sv */
// Types shared by the serial memory slave
`include "eeb_defines.svh"

package eeb_pkg;

    typedef enum logic [3:0] {
        EEB_ST_IDLE,
        EEB_ST_DEVADDR,
        EEB_ST_ADDR_HI,
        EEB_ST_ADDR_LO,
        EEB_ST_WDATA,
        EEB_ST_RDATA,
        EEB_ST_IGNORE
    } eeb_state_t;

    typedef struct packed {
        eeb_state_t                         state;
        logic [3:0]                         bit_cnt;
        logic [`EEB_DATA_W-1:0]             shreg;
        logic [`EEB_ADDR_W-1:0]             addr_ctr;
        logic [`EEB_HI_BITS-1:0]            addr_hi;
        logic                               rw;
        logic                               ack_given;
        logic                               wrote;
        logic                               wp_block;
        logic                               busy;
        logic [`EEB_PROG_W-1:0]             prog_cnt;
        logic                               push;
        logic [`EEB_ADDR_W+`EEB_DATA_W-1:0] push_data;
        logic                               sda_o;
        logic                               sda_oe;
        logic                               scl_s1;
        logic                               scl_s2;
        logic                               scl_d;
        logic                               sda_s1;
        logic                               sda_s2;
        logic                               sda_d;
        logic                               wp_s1;
        logic                               wp_s2;
    } eeb_core_t;

endpackage

/* File: eeb_slave.sv */
// Two-wire serial memory slave: polling, write protect and reads
//
// Notes on behaviour
// - A stop ending a write transfer starts the timed programming cycle.
// - While programming runs, the slave address is not acknowledged.
// - After programming, the polled address is acknowledged; master continues freely.
// - With write protect high, no location is ever programmed.
// - Under write protect, slave address and both address bytes are acknowledged.
// - Under write protect, the first data byte is not acknowledged.
// - A write refused by protection starts no programming cycle at stop.
// - Address counter holds last accessed address plus one; after writes it wraps within the page.
// - Current read acknowledges read address, sends one byte at the counter.
// - Master nacks and stops a single read; device stops driving data.
// - After repeated start, byte at the dummy-written address is sent.
// - Each master acknowledge during a read fetches the next address.
// - Read counting runs over all address bits, no page limit.
// - Past the last location the read counter wraps to zero.
// - Only low five bits of the high address byte are decoded.
// - Last slave address bit: one reads, zero writes.
// - During programming the device ignores all master requests.
`timescale 1ns/1ps
`include "eeb_defines.svh"

module eeb_slave #(
    parameter int PROG_TIME_US = `EEB_PROG_TIME_US,
    parameter int PROG_CYCLES  = PROG_TIME_US * `EEB_CLK_MHZ,
    parameter int FIFO_DEPTH   = `EEB_FIFO_DEPTH
) (
    input  wire logic       core_clk_in,
    input  wire logic       sys_rst_in,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    input  wire logic       wp_in,
    input  wire logic [2:0] dev_sel_in,
    output logic            busy_out
);

    localparam int AW = `EEB_ADDR_W;
    localparam int DW = `EEB_DATA_W;
    localparam int FW = AW + DW;
    localparam logic [`EEB_PROG_W-1:0] PROG_LOAD = `EEB_PROG_W'(PROG_CYCLES - 1);

    eeb_pkg::eeb_core_t r_reg;
    eeb_pkg::eeb_core_t r_next;

    logic          scl_rise;
    logic          scl_fall;
    logic          start_det;
    logic          stop_det;
    logic          fifo_in_ready;
    logic          fifo_out_valid;
    logic [FW-1:0] fifo_out_data;
    logic          mem_wr_en;
    logic [DW-1:0] mem_rd_data;

    // ----------------------------------------------------------------
    // Address arithmetic
    // ----------------------------------------------------------------
    function automatic logic [AW-1:0] addr_plus(input logic [AW-1:0] a, input logic page_wrap);
        logic [AW-1:0] lin;
        lin = a + 1'b1;
        if (page_wrap)
        begin
            addr_plus = {a[AW-1:`EEB_PAGE_BITS], lin[`EEB_PAGE_BITS-1:0]};
        end
        else
        begin
            addr_plus = lin;
        end
    endfunction

    // ----------------------------------------------------------------
    // Bus events from the synchronised lines
    // ----------------------------------------------------------------
    assign scl_rise  = r_reg.scl_s2 && !r_reg.scl_d;
    assign scl_fall  = !r_reg.scl_s2 && r_reg.scl_d;
    assign start_det = r_reg.scl_s2 && r_reg.scl_d && r_reg.sda_d && !r_reg.sda_s2;
    assign stop_det  = r_reg.scl_s2 && r_reg.scl_d && !r_reg.sda_d && r_reg.sda_s2;

    assign mem_wr_en = fifo_out_valid && r_reg.busy && !r_reg.wp_s2;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb
    begin
        logic ack;
        ack = 1'b0;
        r_next = r_reg;
        r_next.scl_s1 = scl_in;
        r_next.scl_s2 = r_reg.scl_s1;
        r_next.scl_d  = r_reg.scl_s2;
        r_next.sda_s1 = sda_in;
        r_next.sda_s2 = r_reg.sda_s1;
        r_next.sda_d  = r_reg.sda_s2;
        r_next.wp_s1  = wp_in;
        r_next.wp_s2  = r_reg.wp_s1;
        r_next.sda_o  = 1'b0;
        r_next.push   = 1'b0;

        // Programming timer; busy holds until buffer is drained
        if (r_reg.busy)
        begin
            if (r_reg.prog_cnt != '0)
            begin
                r_next.prog_cnt = r_reg.prog_cnt - 1'b1;
            end
            else if (!fifo_out_valid)
            begin
                r_next.busy = 1'b0;
            end
        end

        if (start_det || stop_det)
        begin
            if (r_reg.wrote && !r_reg.wp_block)
            begin
                r_next.busy     = 1'b1;
                r_next.prog_cnt = PROG_LOAD;
            end
            r_next.wrote    = 1'b0;
            r_next.wp_block = 1'b0;
            r_next.sda_oe   = 1'b0;
            r_next.bit_cnt  = `EEB_BIT_FIRST;
            r_next.state    = start_det ? eeb_pkg::EEB_ST_DEVADDR : eeb_pkg::EEB_ST_IDLE;
        end
        else
        begin
            case (r_reg.state)
                eeb_pkg::EEB_ST_DEVADDR,
                eeb_pkg::EEB_ST_ADDR_HI,
                eeb_pkg::EEB_ST_ADDR_LO,
                eeb_pkg::EEB_ST_WDATA:
                begin
                    if (scl_rise && r_reg.bit_cnt < `EEB_BIT_LAST)
                    begin
                        r_next.shreg   = {r_reg.shreg[DW-2:0], r_reg.sda_s2};
                        r_next.bit_cnt = r_reg.bit_cnt + 1'b1;
                    end
                    else if (scl_fall && r_reg.bit_cnt == `EEB_BIT_LAST)
                    begin
                        case (r_reg.state)
                            eeb_pkg::EEB_ST_DEVADDR:
                            begin
                                ack = (r_reg.shreg[DW-1:4] == `EEB_DEV_TYPE)
                                      && (r_reg.shreg[3:1] == dev_sel_in)
                                      && !r_reg.busy;
                                r_next.rw = r_reg.shreg[0];
                            end
                            eeb_pkg::EEB_ST_ADDR_HI:
                            begin
                                ack = 1'b1;
                                r_next.addr_hi = r_reg.shreg[`EEB_HI_BITS-1:0];
                            end
                            eeb_pkg::EEB_ST_ADDR_LO:
                            begin
                                ack = 1'b1;
                                r_next.addr_ctr = {r_reg.addr_hi, r_reg.shreg};
                            end
                            eeb_pkg::EEB_ST_WDATA:
                            begin
                                if (r_reg.wp_s2)
                                begin
                                    ack = 1'b0;
                                    r_next.wp_block = 1'b1;
                                end
                                else if (fifo_in_ready)
                                begin
                                    ack = 1'b1;
                                    r_next.push      = 1'b1;
                                    r_next.push_data = {r_reg.addr_ctr, r_reg.shreg};
                                    r_next.addr_ctr  = addr_plus(r_reg.addr_ctr, 1'b1);
                                    r_next.wrote     = 1'b1;
                                end
                                else
                                begin
                                    ack = 1'b0;
                                end
                            end
                            default:
                            begin
                                ack = 1'b0;
                            end
                        endcase
                        r_next.ack_given = ack;
                        r_next.sda_oe    = ack;
                        r_next.bit_cnt   = `EEB_BIT_ACK;
                    end
                    else if (scl_fall && r_reg.bit_cnt == `EEB_BIT_ACK)
                    begin
                        r_next.sda_oe  = 1'b0;
                        r_next.bit_cnt = `EEB_BIT_FIRST;
                        if (!r_reg.ack_given)
                        begin
                            r_next.state = eeb_pkg::EEB_ST_IGNORE;
                        end
                        else
                        begin
                            case (r_reg.state)
                                eeb_pkg::EEB_ST_DEVADDR:
                                begin
                                    if (r_reg.rw == `EEB_DIR_READ)
                                    begin
                                        // First byte from counter address
                                        r_next.state    = eeb_pkg::EEB_ST_RDATA;
                                        r_next.sda_oe   = !mem_rd_data[DW-1];
                                        r_next.shreg    = {mem_rd_data[DW-2:0], 1'b0};
                                        r_next.addr_ctr = addr_plus(r_reg.addr_ctr, 1'b0);
                                    end
                                    else
                                    begin
                                        r_next.state = eeb_pkg::EEB_ST_ADDR_HI;
                                    end
                                end
                                eeb_pkg::EEB_ST_ADDR_HI:
                                begin
                                    r_next.state = eeb_pkg::EEB_ST_ADDR_LO;
                                end
                                default:
                                begin
                                    r_next.state = eeb_pkg::EEB_ST_WDATA;
                                end
                            endcase
                        end
                    end
                end

                eeb_pkg::EEB_ST_RDATA:
                begin
                    if (scl_rise)
                    begin
                        if (r_reg.bit_cnt < `EEB_BIT_LAST)
                        begin
                            r_next.bit_cnt = r_reg.bit_cnt + 1'b1;
                        end
                        else if (r_reg.bit_cnt == `EEB_BIT_LAST)
                        begin
                            if (!r_reg.sda_s2)
                            begin
                                r_next.bit_cnt = `EEB_BIT_ACK;
                            end
                            else
                            begin
                                r_next.state = eeb_pkg::EEB_ST_IGNORE;
                            end
                        end
                    end
                    else if (scl_fall && r_reg.bit_cnt != `EEB_BIT_FIRST)
                    begin
                        if (r_reg.bit_cnt < `EEB_BIT_LAST)
                        begin
                            r_next.sda_oe = !r_reg.shreg[DW-1];
                            r_next.shreg  = {r_reg.shreg[DW-2:0], 1'b0};
                        end
                        else if (r_reg.bit_cnt == `EEB_BIT_LAST)
                        begin
                            r_next.sda_oe = 1'b0;
                        end
                        else
                        begin
                            // Next byte, counter runs over the whole array
                            r_next.sda_oe   = !mem_rd_data[DW-1];
                            r_next.shreg    = {mem_rd_data[DW-2:0], 1'b0};
                            r_next.addr_ctr = addr_plus(r_reg.addr_ctr, 1'b0);
                            r_next.bit_cnt  = `EEB_BIT_FIRST;
                        end
                    end
                end

                eeb_pkg::EEB_ST_IGNORE:
                begin
                    r_next.sda_oe = 1'b0;
                end

                default:
                begin
                    r_next.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            r_reg <= '0;
        end
        else
        begin
            r_reg <= r_next;
        end
    end

    // ----------------------------------------------------------------
    // Write buffer and array
    // ----------------------------------------------------------------
    eeb_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk_in   (core_clk_in),
        .sys_rst_in    (sys_rst_in),
        .in_valid_in   (r_reg.push),
        .in_ready_out  (fifo_in_ready),
        .in_data_in    (r_reg.push_data),
        .out_valid_out (fifo_out_valid),
        .out_ready_in  (r_reg.busy),
        .out_data_out  (fifo_out_data)
    );

    eeb_mem #(
        .ADDR_W (AW),
        .DATA_W (DW)
    ) u_mem (
        .core_clk_in (core_clk_in),
        .sys_rst_in  (sys_rst_in),
        .wr_en_in    (mem_wr_en),
        .wr_addr_in  (fifo_out_data[FW-1:DW]),
        .wr_data_in  (fifo_out_data[DW-1:0]),
        .rd_addr_in  (r_reg.addr_ctr),
        .rd_data_out (mem_rd_data)
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign sda_out    = r_reg.sda_o;
    assign sda_oe_out = r_reg.sda_oe;
    assign busy_out   = r_reg.busy;

endmodule

/* File: eeb_slave_props.sv */
// Checker of the serial memory slave port behaviour
`timescale 1ns/1ps

module eeb_slave_props #(
    parameter int PROG_CYCLES = 500000
) (
    input wire logic       core_clk_in,
    input wire logic       sys_rst_in,
    input wire logic       scl_in,
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe_out,
    input wire logic       wp_in,
    input wire logic [2:0] dev_sel_in,
    input wire logic       busy_out
);
    logic [31:0] busy_cnt;
    logic [7:0]  edge_age;
    logic [15:0] wp_cnt;

    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in);

    // Busy length, age of last start or stop, protect duration
    always_ff @(posedge core_clk_in)
    begin
        if (sys_rst_in)
        begin
            busy_cnt <= 32'h0;
            edge_age <= 8'hff;
            wp_cnt   <= 16'h0;
        end
        else
        begin
            busy_cnt <= busy_out ? busy_cnt + 32'h1 : 32'h0;
            edge_age <= (scl_in && $changed(sda_in)) ? 8'h0 : (edge_age == 8'hff) ? edge_age : edge_age + 8'h1;
            wp_cnt   <= !wp_in ? 16'h0 : (wp_cnt == 16'hffff) ? wp_cnt : wp_cnt + 16'h1;
        end
    end

    property p_start_at_stop; $rose(busy_out) |-> edge_age < 8'h10; endproperty
    a_start_at_stop: assert property (p_start_at_stop) else $error("busy without stop");
    property p_prog_len; $fell(busy_out) |-> busy_cnt >= PROG_CYCLES; endproperty
    a_prog_len: assert property (p_prog_len) else $error("programming too short");
    property p_busy_quiet; busy_out |-> !sda_oe_out; endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");
    property p_busy_hold; $rose(busy_out) |-> busy_out [*8]; endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");
    property p_wp_noprog; $rose(busy_out) |-> wp_cnt < 16'h02bc; endproperty
    a_wp_noprog: assert property (p_wp_noprog) else $error("programming under protect");
    property p_scl_low; $changed(sda_oe_out) |-> !scl_in; endproperty
    a_scl_low: assert property (p_scl_low) else $error("data moved with clock high");
    property p_stop_rel; (scl_in && $rose(sda_in)) |-> !sda_oe_out [*8]; endproperty
    a_stop_rel: assert property (p_stop_rel) else $error("drive after stop");
    property p_open_drain; sda_out == 1'b0; endproperty
    a_open_drain: assert property (p_open_drain) else $error("data driven high");
endmodule

/* File: eeb_slave_tb.sv */
// Self-checking testbench of the serial memory slave
`timescale 1ns/1ps
`include "eeb_defines.svh"

bind eeb_slave eeb_slave_props #(.PROG_CYCLES(PROG_CYCLES)) eeb_slave_props_i (.core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out),
    .wp_in(wp_in), .dev_sel_in(dev_sel_in), .busy_out(busy_out));

module eeb_slave_tb;
    localparam logic [2:0] SEL  = 3'h5;
    localparam logic [7:0] SA_W = {`EEB_DEV_TYPE, SEL, 1'b0};
    localparam logic [7:0] SA_R = {`EEB_DEV_TYPE, SEL, 1'b1};
    logic       core_clk_in = 1'b0;
    logic       sys_rst_in  = 1'b1;
    logic       wp_in       = 1'b0;
    logic [2:0] dev_sel     = SEL;
    logic       scl, m_oe, s_oe, busy, ack;
    wire        sda = ~(m_oe | s_oe);
    logic [7:0] q;
    int         num_errors = 0;
    int         n_compared = 0;

    always #5 core_clk_in = ~core_clk_in;
    eeb_slave #(.PROG_CYCLES(400)) eeb_slave_i (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in),
        .scl_in(scl), .sda_in(sda), .sda_out(), .sda_oe_out(s_oe), .wp_in(wp_in), .dev_sel_in(dev_sel),
        .busy_out(busy));
    eeb_mm eeb_mm_i (.core_clk_in(core_clk_in), .sda_in(sda), .scl_out(scl), .sda_oe_out(m_oe));

    task automatic test_done();
        if (num_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic check(input logic ok, input string msg);
        n_compared++;
        if (!ok)
        begin
            $display("CHECK FAILED at %0t: %s", $time, msg);
            num_errors++;
        end
    endtask
    task automatic send(input logic [7:0] d, input logic want);
        eeb_mm_i.xfer(d, 1'b1, q, ack);
        check(ack === want, "byte acknowledge");
    endtask
    task automatic addr(input logic [15:0] a);
        send(a[15:8], 1'b1);
        send(a[7:0], 1'b1);
    endtask
    task automatic hdr(input logic [15:0] a);
        eeb_mm_i.start();
        send(SA_W, 1'b1);
        addr(a);
    endtask
    task automatic rstart();
        eeb_mm_i.start();
        send(SA_R, 1'b1);
    endtask
    task automatic rd(input logic mack, input logic [7:0] exp);
        eeb_mm_i.xfer(8'hff, mack, q, ack);
        check(q === exp, "read data");
    endtask
    task automatic poll(output int n);
        n = 0;
        ack = 1'b0;
        while (ack !== 1'b1 && n < 20)
        begin
            eeb_mm_i.start();
            eeb_mm_i.xfer(SA_W, 1'b1, q, ack);
            if (ack !== 1'b1)
            begin
                eeb_mm_i.stop();
                n++;
            end
        end
    endtask
    task automatic t_poll();
        int n;
        hdr(16'he000);
        send(8'h3c, 1'b1);
        eeb_mm_i.stop();
        eeb_mm_i.tick(12);
        check(busy === 1'b1, "busy after stop");
        poll(n);
        check(n > 0, "poll acked while busy");
        check(ack === 1'b1, "poll not acked");
        addr(16'h1ffe);
        send(8'hc3, 1'b1);
        send(8'h96, 1'b1);
        eeb_mm_i.stop();
    endtask
    task automatic t_reads();
        int n;
        poll(n);
        check(ack === 1'b1, "poll not acked");
        addr(16'h1ffe);
        rstart();
        rd(1'b1, 8'hc3);
        eeb_mm_i.stop();
        rstart();
        rd(1'b0, 8'h96);
        rd(1'b1, 8'h3c);
        eeb_mm_i.stop();
        eeb_mm_i.tick(4);
        check(s_oe === 1'b0, "line held after read");
    endtask
    task automatic t_wp();
        wp_in = 1'b1;
        eeb_mm_i.tick(800);
        hdr(16'h0000);
        send(8'h55, 1'b0);
        eeb_mm_i.stop();
        eeb_mm_i.tick(20);
        check(busy === 1'b0, "programming under protect");
        wp_in = 1'b0;
        hdr(16'h0000);
        rstart();
        rd(1'b1, 8'h3c);
        eeb_mm_i.stop();
    endtask
    task automatic t_sel();
        eeb_mm_i.start();
        send({`EEB_DEV_TYPE, ~SEL, 1'b1}, 1'b0);
        rd(1'b1, 8'hff);
        eeb_mm_i.stop();
        // Restrapped select: old code refused, new code served
        dev_sel = ~SEL;
        eeb_mm_i.start();
        send(SA_R, 1'b0);
        eeb_mm_i.stop();
        eeb_mm_i.start();
        send({`EEB_DEV_TYPE, ~SEL, 1'b0}, 1'b1);
        addr(16'h0000);
        eeb_mm_i.start();
        send({`EEB_DEV_TYPE, ~SEL, 1'b1}, 1'b1);
        rd(1'b1, 8'h3c);
        eeb_mm_i.stop();
        dev_sel = SEL;
    endtask

    initial
    begin
        repeat (3) @(posedge core_clk_in);
        #1;
        sys_rst_in = 1'b0;
        eeb_mm_i.tick(4);
        t_poll();
        t_reads();
        t_wp();
        t_sel();
        test_done();
    end
    initial
    begin
        repeat (40000) @(posedge core_clk_in);
        num_errors++;
        test_done();
    end
endmodule
